// [hw/adccd_pkg.sv]
// Shared constants and carrier types for the converter correction and DMA block
package adccd_pkg;

  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int STARTUP_NS = 21000;
  localparam int STARTUP_CYCLES = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_OFFSET = 8'h04;
  localparam logic [7:0] OFS_GAIN = 8'h08;
  localparam logic [7:0] OFS_BEG = 8'h0c;
  localparam logic [7:0] OFS_SIZE = 8'h10;
  localparam logic [7:0] OFS_XFER_CFG = 8'h14;
  localparam logic [7:0] OFS_CUR = 8'h18;
  localparam logic [7:0] OFS_FLAGS = 8'h1c;

  // Converter configuration fields
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_PERIOD_LSB = 1;
  localparam int PERIOD_W = 3;

  // Transfer configuration fields
  localparam int XFER_LOAD_BIT = 0;
  localparam int XFER_WRAP_BIT = 1;
  localparam int XFER_STOPPED_BIT = 2;
  localparam int XFER_RESET_BIT = 4;

  // Event flag positions
  localparam int FLG_SAT = 0;
  localparam int FLG_HALF = 1;
  localparam int FLG_FULL = 2;
  localparam int FLG_OVF = 3;
  localparam int FLG_W = 4;

  // Reset values
  localparam logic [15:0] GAIN_RST = 16'h8000;
  localparam logic [15:0] OFFSET_RST = 16'h0000;
  localparam logic [31:0] BEG_RST = 32'h0000_0000;
  localparam logic [15:0] SIZE_RST = 16'h0000;

  // Arithmetic
  localparam int GAIN_FRAC_BITS = 15;
  localparam logic [15:0] SAT_MAX = 16'h7fff;
  localparam logic [15:0] SAT_MIN = 16'h8000;
  localparam int SIG_BITS_BASE = 5;
  localparam logic [31:0] SAMPLE_BYTES = 32'h0000_0002;

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } adccd_sample_t;

  typedef struct packed {
    logic we;
    logic [31:0] addr;
    logic [15:0] data;
  } adccd_ramwr_t;

endpackage : adccd_pkg

// [hw/adccd_correct.sv]
// Offset add, fixed-point gain and saturation of one raw sample
`timescale 1ns/1ns
module adccd_correct (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Settings
  input wire logic [15:0] offset,
  input wire logic [15:0] gain,
  // Samples
  input wire adccd_pkg::adccd_sample_t rawIn,
  output adccd_pkg::adccd_sample_t corrOut,
  output logic satPulse
);
  import adccd_pkg::*;

  typedef struct packed {
    adccd_sample_t out;
    logic sat;
  } adccd_corr_state_t;

  adccd_corr_state_t state_ff;
  adccd_corr_state_t nxt_state;
  logic signed [16:0] sum;
  logic signed [33:0] prod;
  logic signed [33:0] scaled;

  always_comb begin
    sum = 17'(signed'(rawIn.data)) + 17'(signed'(offset));
    prod = 34'(sum) * 34'(signed'({1'b0, gain}));
    scaled = prod >>> GAIN_FRAC_BITS;
    nxt_state = state_ff;
    nxt_state.out.valid = rawIn.valid;
    nxt_state.sat = 1'b0;
    if (rawIn.valid) begin
      if (scaled > 34'(signed'(SAT_MAX))) begin
        nxt_state.out.data = SAT_MAX;
        nxt_state.sat = 1'b1;
      end else if (scaled < 34'(signed'(SAT_MIN))) begin
        nxt_state.out.data = SAT_MIN;
        nxt_state.sat = 1'b1;
      end else begin
        nxt_state.out.data = scaled[15:0];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= '0;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  assign corrOut = state_ff.out;
  assign satPulse = state_ff.sat;

endmodule : adccd_correct

// [hw/adccd_conv_seq.sv]
// Converter run control: startup wait, discard of first result, result masking
`timescale 1ns/1ns
module adccd_conv_seq #(
  parameter int STARTUP_CYCLES = adccd_pkg::STARTUP_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Control
  input wire logic enable,
  input wire logic cfgChange,
  input wire logic [adccd_pkg::PERIOD_W-1:0] period,
  // Front end
  input wire logic convDone,
  input wire logic [15:0] convData,
  output logic convRun,
  // Accepted results
  output adccd_pkg::adccd_sample_t rawOut
);
  import adccd_pkg::*;

  localparam int CNT_W = $clog2(STARTUP_CYCLES + 1);

  typedef enum logic [1:0] {SEQ_OFF, SEQ_WARM, SEQ_DISCARD, SEQ_RUN} adccd_seq_phase_t;

  typedef struct packed {
    adccd_seq_phase_t phase;
    logic [CNT_W-1:0] cnt;
    logic run;
    adccd_sample_t out;
  } adccd_seq_state_t;

  adccd_seq_state_t state_ff;
  adccd_seq_state_t nxt_state;

  // Keeps the significant top bits for the selected sample length
  function automatic logic [15:0] sigMask(input logic [PERIOD_W-1:0] p);
    sigMask = 16'hffff << (16 - SIG_BITS_BASE - int'(p));
  endfunction : sigMask

  always_comb begin
    nxt_state = state_ff;
    nxt_state.out.valid = 1'b0;
    if (!enable) begin
      nxt_state.phase = SEQ_OFF;
      nxt_state.run = 1'b0;
      nxt_state.cnt = '0;
    end else begin
      unique case (state_ff.phase)
        SEQ_OFF: begin
          nxt_state.phase = SEQ_WARM;
          nxt_state.cnt = '0;
        end
        SEQ_WARM: begin
          if (state_ff.cnt == CNT_W'(STARTUP_CYCLES - 1)) begin
            nxt_state.phase = SEQ_DISCARD;
            nxt_state.run = 1'b1;
          end else begin
            nxt_state.cnt = state_ff.cnt + CNT_W'(1);
          end
        end
        SEQ_DISCARD: begin
          if (convDone && !cfgChange) begin
            nxt_state.phase = SEQ_RUN;
          end
        end
        SEQ_RUN: begin
          if (cfgChange) begin
            nxt_state.phase = SEQ_DISCARD;
          end else if (convDone) begin
            nxt_state.out.valid = 1'b1;
            nxt_state.out.data = convData & sigMask(period);
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= '{phase: SEQ_OFF, cnt: '0, run: 1'b0, out: '0};
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  assign convRun = state_ff.run;
  assign rawOut = state_ff.out;

endmodule : adccd_conv_seq

// [hw/adccd_top.sv]
// Converter back end: registers over AXI4-Lite, correction and sample DMA
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
// Contract
// - Add signed offset register to each completed raw conversion.
// - Multiply offset-corrected sample by gain giving signed 16-bit result.
// - Clamp to 0x7fff or 0x8000 on overflow and raise saturation flag.
// - Gain is unsigned, bit 15 integer, bits 14..0 fraction.
// - Reset gives offset zero and gain exactly one.
// - DMA stores corrected samples into the RAM buffer.
// - Buffer size counts 16-bit samples.
// - Channel reset first, then load; transfers start only after load.
// - Wraparound select 0 means linear, 1 means auto-wrap.
// - Linear: after size samples, stop channel and set buffer-full flag.
// - Linear: sample after full, before reset or disable, sets overrun.
// - Auto-wrap: after last location pointer returns to start, continues.
// - Auto-wrap runs until converter disabled or channel reset.
// - Half flag when lower half filled, full flag when upper half.
// - Current write address readable in current-pointer register.
// - Enabled converter produces conversions back to back until disabled.
// - Startup delay after enabling from disabled before conversions start.
// - First conversion after startup or configuration change is discarded.
// - Samples are 16 bits, significant bits left-aligned.
module adccd_top #(
  parameter int STARTUP_CYCLES = adccd_pkg::STARTUP_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Converter front end
  input wire logic convDone,
  input wire logic [15:0] convData,
  output logic convRun,
  // RAM write port
  output adccd_pkg::adccd_ramwr_t ramWr
);
  import adccd_pkg::*;

  typedef struct packed {
    logic awHave;
    logic wHave;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic cfgEn;
    logic [PERIOD_W-1:0] cfgPeriod;
    logic [15:0] offset;
    logic [15:0] gain;
    logic [31:0] beg;
    logic [15:0] size;
    logic autowrap;
    logic active;
    logic stopped;
    logic [31:0] cur;
    logic [15:0] idx;
    logic [FLG_W-1:0] flags;
    adccd_ramwr_t ram;
  } adccd_top_state_t;

  adccd_top_state_t state_ff;
  adccd_top_state_t nxt_state;
  adccd_sample_t rawSample;
  adccd_sample_t corrSample;
  logic satPulse;
  logic cfgChange;
  logic doWrite;
  logic [FLG_W-1:0] flagSet;
  logic [FLG_W-1:0] flagClr;
  logic [15:0] idxNext;
  logic [31:0] rdVal;

  function automatic logic isMapped(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    isMapped = (w == OFS_CFG) || (w == OFS_OFFSET) || (w == OFS_GAIN) || (w == OFS_BEG) ||
               (w == OFS_SIZE) || (w == OFS_XFER_CFG) || (w == OFS_CUR) || (w == OFS_FLAGS);
  endfunction : isMapped

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        old[8*i +: 8] = nw[8*i +: 8];
      end
    end
    merge = old;
  endfunction : merge

  adccd_conv_seq #(
    .STARTUP_CYCLES(STARTUP_CYCLES)
  ) u_seq (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .enable(state_ff.cfgEn),
    .cfgChange(cfgChange),
    .period(state_ff.cfgPeriod),
    .convDone(convDone),
    .convData(convData),
    .convRun(convRun),
    .rawOut(rawSample)
  );

  adccd_correct u_corr (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .offset(state_ff.offset),
    .gain(state_ff.gain),
    .rawIn(rawSample),
    .corrOut(corrSample),
    .satPulse(satPulse)
  );

  // Read data mux
  always_comb begin
    unique case ({s_axi_araddr[7:2], 2'b00})
      OFS_CFG: rdVal = 32'({state_ff.cfgPeriod, state_ff.cfgEn});
      OFS_OFFSET: rdVal = 32'(state_ff.offset);
      OFS_GAIN: rdVal = 32'(state_ff.gain);
      OFS_BEG: rdVal = state_ff.beg;
      OFS_SIZE: rdVal = 32'(state_ff.size);
      OFS_XFER_CFG: rdVal = 32'({state_ff.stopped, state_ff.autowrap, state_ff.active});
      OFS_CUR: rdVal = state_ff.cur;
      OFS_FLAGS: rdVal = 32'(state_ff.flags);
      default: rdVal = 32'h0000_0000;
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_state.ram.we = 1'b0;
    flagSet = '0;
    flagClr = '0;
    idxNext = state_ff.idx + 16'h0001;
    doWrite = state_ff.awHave && state_ff.wHave && !state_ff.bvalid;
    cfgChange = doWrite && state_ff.cfgEn && ({state_ff.awAddr[7:2], 2'b00} == OFS_CFG);

    // Write address and data, taken in either order
    if (s_axi_awvalid && state_ff.awready) begin
      nxt_state.awHave = 1'b1;
      nxt_state.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && state_ff.wready) begin
      nxt_state.wHave = 1'b1;
      nxt_state.wData = s_axi_wdata;
      nxt_state.wStrb = s_axi_wstrb;
    end
    if (state_ff.bvalid && s_axi_bready) begin
      nxt_state.bvalid = 1'b0;
    end

    // Sample transfer
    if (corrSample.valid) begin
      if (state_ff.active) begin
        nxt_state.ram.we = 1'b1;
        nxt_state.ram.addr = state_ff.cur;
        nxt_state.ram.data = corrSample.data;
        nxt_state.idx = idxNext;
        nxt_state.cur = state_ff.cur + SAMPLE_BYTES;
        if (idxNext == (state_ff.size >> 1)) begin
          flagSet[FLG_HALF] = 1'b1;
        end
        if (idxNext == state_ff.size) begin
          flagSet[FLG_FULL] = 1'b1;
          if (state_ff.autowrap) begin
            nxt_state.cur = state_ff.beg;
            nxt_state.idx = '0;
          end else begin
            nxt_state.active = 1'b0;
            nxt_state.stopped = 1'b1;
          end
        end
      end else if (state_ff.stopped) begin
        flagSet[FLG_OVF] = 1'b1;
      end
    end
    if (satPulse) begin
      flagSet[FLG_SAT] = 1'b1;
    end
    if (!state_ff.cfgEn) begin
      nxt_state.stopped = 1'b0;
    end

    // Register write
    if (doWrite) begin
      nxt_state.awHave = 1'b0;
      nxt_state.wHave = 1'b0;
      nxt_state.bvalid = 1'b1;
      nxt_state.bresp = isMapped(state_ff.awAddr) ? RESP_OKAY : RESP_SLVERR;
      unique case ({state_ff.awAddr[7:2], 2'b00})
        OFS_CFG: begin
          if (state_ff.wStrb[0]) begin
            nxt_state.cfgEn = state_ff.wData[CFG_EN_BIT];
            nxt_state.cfgPeriod = state_ff.wData[CFG_PERIOD_LSB +: PERIOD_W];
          end
        end
        OFS_OFFSET: nxt_state.offset = 16'(merge(32'(state_ff.offset), state_ff.wData, state_ff.wStrb));
        OFS_GAIN: nxt_state.gain = 16'(merge(32'(state_ff.gain), state_ff.wData, state_ff.wStrb));
        OFS_BEG: nxt_state.beg = merge(state_ff.beg, state_ff.wData, state_ff.wStrb);
        OFS_SIZE: nxt_state.size = 16'(merge(32'(state_ff.size), state_ff.wData, state_ff.wStrb));
        OFS_XFER_CFG: begin
          if (state_ff.wStrb[0]) begin
            nxt_state.autowrap = state_ff.wData[XFER_WRAP_BIT];
            if (state_ff.wData[XFER_RESET_BIT]) begin
              nxt_state.active = 1'b0;
              nxt_state.stopped = 1'b0;
              nxt_state.cur = state_ff.beg;
              nxt_state.idx = '0;
              nxt_state.ram.we = 1'b0;
            end
            if (state_ff.wData[XFER_LOAD_BIT]) begin
              nxt_state.active = 1'b1;
              nxt_state.stopped = 1'b0;
              nxt_state.cur = state_ff.beg;
              nxt_state.idx = '0;
              nxt_state.ram.we = 1'b0;
            end
          end
        end
        OFS_FLAGS: begin
          if (state_ff.wStrb[0]) begin
            flagClr = state_ff.wData[FLG_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end
    nxt_state.flags = (state_ff.flags & ~flagClr) | flagSet;
    nxt_state.awready = !nxt_state.awHave && !nxt_state.bvalid;
    nxt_state.wready = !nxt_state.wHave && !nxt_state.bvalid;

    // Register read
    if (state_ff.rvalid && s_axi_rready) begin
      nxt_state.rvalid = 1'b0;
    end
    if (s_axi_arvalid && state_ff.arready) begin
      nxt_state.rvalid = 1'b1;
      nxt_state.rdata = rdVal;
      nxt_state.rresp = isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    nxt_state.arready = !nxt_state.rvalid;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= '0;
      state_ff.awready <= 1'b1;
      state_ff.wready <= 1'b1;
      state_ff.arready <= 1'b1;
      state_ff.offset <= OFFSET_RST;
      state_ff.gain <= GAIN_RST;
      state_ff.beg <= BEG_RST;
      state_ff.size <= SIZE_RST;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  assign s_axi_awready = state_ff.awready;
  assign s_axi_wready = state_ff.wready;
  assign s_axi_bvalid = state_ff.bvalid;
  assign s_axi_bresp = state_ff.bresp;
  assign s_axi_arready = state_ff.arready;
  assign s_axi_rvalid = state_ff.rvalid;
  assign s_axi_rdata = state_ff.rdata;
  assign s_axi_rresp = state_ff.rresp;
  assign ramWr = state_ff.ram;

endmodule : adccd_top

// [verif/adccd_monitor.sv]
// Concurrent checks on the converter back end ports
`timescale 1ns/1ns
module adccd_monitor #(
  parameter int STARTUP_CYCLES = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Converter and RAM
  input wire logic convDone,
  input wire logic convRun,
  input wire adccd_pkg::adccd_ramwr_t ramWr
);
  import adccd_pkg::*;
  logic [7:0] startCnt_ff;
  logic [7:0] nxt_startCnt;
  // Cycles since the last register write finished
  always_comb begin
    nxt_startCnt = startCnt_ff;
    if (s_axi_bvalid && s_axi_bready) nxt_startCnt = 8'h00;
    else if (startCnt_ff != 8'hff) nxt_startCnt = startCnt_ff + 8'h01;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) startCnt_ff <= 8'h00;
    else startCnt_ff <= nxt_startCnt;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_WE_CAUSE: assert property (ramWr.we |-> $past(convDone, 3))
    else $error("RAM write without a conversion three cycles earlier");
  AST_ADDR_EVEN: assert property (ramWr.we |-> !ramWr.addr[0])
    else $error("RAM write to an odd byte address");
  AST_STARTUP: assert property ($rose(convRun) |-> startCnt_ff >= STARTUP_CYCLES - 2)
    else $error("Converter started before the startup delay");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read data not valid one cycle after address");
  AST_AR_FREE: assert property (!s_axi_rvalid |-> s_axi_arready)
    else $error("Read address refused while idle");
  AST_RD_ONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("Read data held after acceptance");
  AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("Write response not two cycles after take");
  AST_WR_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("Write channels ready while response pending");
  AST_B_ONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("Write response held after acceptance");
endmodule : adccd_monitor

// [verif/adccd_ram_model.sv]
// Behavioural RAM on the sample write port
`timescale 1ns/1ns
module adccd_ram_model (
  // Clock
  input wire logic clk,
  // Write port
  input wire adccd_pkg::adccd_ramwr_t ramWr,
  // Observation
  output int writeCount,
  output logic [31:0] lastAddr,
  output logic [15:0] lastData
);
  import adccd_pkg::*;
  logic [15:0] mem [0:511];
  initial writeCount = 0;
  always @(posedge clk) begin
    if (ramWr.we === 1'b1) begin
      mem[ramWr.addr[9:1]] <= ramWr.data;
      lastAddr <= ramWr.addr;
      lastData <= ramWr.data;
      writeCount <= writeCount + 1;
    end
  end
endmodule : adccd_ram_model

// [verif/testbench.sv]
// Self-checking bench for the converter back end
`timescale 1ns/1ns
bind adccd_top adccd_monitor #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_adccd_monitor (.clk, .rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .convDone, .convRun, .ramWr);
module testbench;
  import adccd_pkg::*;
  typedef struct packed {
    logic [15:0] off;
    logic [15:0] gain;
    logic [15:0] raw;
    logic [15:0] res;
    logic sat;
  } adccd_row_t;
  localparam int SU = 8;
  localparam adccd_row_t ROWS [8] = '{'{16'h0000, 16'h8000, 16'h1230, 16'h1230, 1'b0},
    '{16'h0010, 16'h8000, 16'hfff0, 16'h0000, 1'b0}, '{16'h0000, 16'h4000, 16'h2000, 16'h1000, 1'b0},
    '{16'h0000, 16'hffff, 16'h7ff0, 16'h7fff, 1'b1}, '{16'h8000, 16'h8000, 16'h8000, 16'h8000, 1'b1},
    '{16'h0000, 16'h0000, 16'h5670, 16'h0000, 1'b0}, '{16'h0100, 16'hc000, 16'hf000, 16'he980, 1'b0},
    '{16'h7fff, 16'h8000, 16'h7ff0, 16'h7fff, 1'b1}};
  logic clk, rst, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, convDone;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, convRun;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, ramAddr;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] convData, ramData;
  adccd_ramwr_t ramWr;
  int fails, num_checks, ramCount;

  adccd_top #(.STARTUP_CYCLES(SU)) u_adccd_top (.clk, .rst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .convDone, .convData, .convRun, .ramWr);
  adccd_ram_model u_adccd_ram_model (.clk, .ramWr, .writeCount(ramCount), .lastAddr(ramAddr), .lastData(ramData));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    chk(s_axi_bvalid, 1'b1);
    chk(s_axi_bresp, er);
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [31:0] m = 32'hffffffff,
    input logic [1:0] er = RESP_OKAY);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    chk(s_axi_rvalid, 1'b1);
    chk(s_axi_rdata & m, ed);
    chk(s_axi_rresp, er);
  endtask : axr

  task automatic conv(input logic [15:0] d, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      convDone <= 1'b1;
      convData <= d + 16'(i * 16);
    end
    @(posedge clk);
    convDone <= 1'b0;
  endtask : conv

  task automatic waitwr(input int target);
    int n;
    n = 0;
    while (ramCount != target && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk(ramCount, target);
  endtask : waitwr

  task automatic waitrun();
    for (int i = 0; i < 100 && convRun !== 1'b1; i++) @(posedge clk);
    chk(convRun, 1'b1);
  endtask : waitrun

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    results();
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    s_axi_wstrb = 4'hf;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, convDone} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, convData} = '0;
    repeat (8) @(posedge clk);
    chk({convRun, ramWr.we, s_axi_awready, s_axi_arready}, 4'h3);
    rst <= 1'b0;
    @(posedge clk);
    axr(OFS_GAIN, 32'h8000);
    axr(OFS_OFFSET, 32'h0);
    axr(OFS_CUR, 32'h0);
    axr(OFS_FLAGS, 32'h0);
    axr(8'h20, 32'h0, 32'hffffffff, RESP_SLVERR);
    axw(8'h24, 32'h1234, RESP_SLVERR);
    axw(OFS_BEG, 32'h100);
    axw(OFS_SIZE, 32'h8);
    axw(OFS_CFG, 32'hf);
    waitrun();
    axw(OFS_XFER_CFG, 32'h10);
    conv(16'h4440, 2);
    repeat (10) @(posedge clk);
    waitwr(0);
    axw(OFS_XFER_CFG, 32'h3);
    axr(OFS_XFER_CFG, 32'h3, 32'h7);
    for (int i = 0; i < 8; i++) begin
      axw(OFS_OFFSET, ROWS[i].off);
      axw(OFS_GAIN, ROWS[i].gain);
      conv(ROWS[i].raw, 1);
      waitwr(i + 1);
      chk(ramData, ROWS[i].res);
      chk(ramAddr, 32'h100 + 32'(2 * i));
      axr(OFS_FLAGS, ROWS[i].sat, 32'h1);
      axw(OFS_FLAGS, 32'h1);
    end
    axr(OFS_CUR, 32'h100);
    axr(OFS_FLAGS, 32'h6, 32'he);
    conv(16'h0100, 1);
    waitwr(9);
    chk(ramAddr, 32'h100);
    axw(OFS_OFFSET, 32'h0);
    axw(OFS_GAIN, 32'h8000);
    axw(OFS_XFER_CFG, 32'h10);
    axw(OFS_BEG, 32'h200);
    axw(OFS_SIZE, 32'h2);
    axw(OFS_XFER_CFG, 32'h1);
    axw(OFS_FLAGS, 32'hf);
    conv(16'h1110, 2);
    waitwr(11);
    chk(ramAddr, 32'h202);
    chk(u_adccd_ram_model.mem[9'h100], 16'h1110);
    chk(ramData, 16'h1120);
    axr(OFS_XFER_CFG, 32'h4, 32'h7);
    axr(OFS_FLAGS, 32'h4, 32'hc);
    conv(16'h3330, 1);
    repeat (10) @(posedge clk);
    waitwr(11);
    axr(OFS_FLAGS, 32'hc, 32'hc);
    axw(OFS_XFER_CFG, 32'h10);
    axw(OFS_XFER_CFG, 32'h1);
    axw(OFS_CFG, 32'h1);
    waitrun();
    conv(16'hffff, 1);
    conv(16'hffff, 1);
    repeat (10) @(posedge clk);
    waitwr(12);
    chk(ramData, 16'hf800);
    chk(ramAddr, 32'h200);
    axr(OFS_CUR, 32'h202);
    // Conversion offered while frozen must be lost
    ce <= 1'b0;
    conv(16'h4000, 1);
    repeat (4) @(posedge clk);
    chk({convRun, ramWr.we}, 2'h2);
    ce <= 1'b1;
    repeat (6) @(posedge clk);
    waitwr(12);
    axw(OFS_CFG, 32'h0);
    repeat (4) @(posedge clk);
    chk(convRun, 1'b0);
    // Reset with the converter disabled restores the correction defaults
    axw(OFS_OFFSET, 32'h1234);
    axw(OFS_GAIN, 32'h0001);
    rst <= 1'b1;
    @(posedge clk);
    chk({s_axi_bvalid, s_axi_rvalid, s_axi_awready, s_axi_arready}, 4'h3);
    rst <= 1'b0;
    @(posedge clk);
    axr(OFS_OFFSET, 32'h0);
    axr(OFS_GAIN, 32'h8000);
    axr(OFS_XFER_CFG, 32'h0, 32'h7);
    results();
  end
endmodule : testbench
